// ### hw/rcld_top.sv
// Remote capability store and link-detect timer
//
// Overview of operation
// R1 - Role bit: 0 primary, 1 secondary
// R2 - After lock, auto-load all capability fields
// R3 - Software writes need hold bit set too
// R4 - Hold bit 7 stops auto-load, keeps values
// R5 - Port select shows second port's capabilities
// R6 - Bit 1: wide video with HD sound
// R7 - Bit 0: forward frame GPIO support
// R8 - Mode = second[1:0] over first bit 6
// R9 - Modes 000-011 GPIO, 100-101 reserved
// R10 - 110 forward SPI, 111 reverse SPI
// R11 - Timer expiry without traffic drops link detect
// R12 - Timeout code selects one of eight periods
// R13 - Valid reverse traffic restarts the timer
`timescale 1ns/10ps
module rcld_top
    import rcld_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_second_port_view_select,
    input  wire logic       i_lock_port0,
    input  wire logic       i_lock_port1,
    input  wire rcld_cap_t  i_remote_cap_port0,
    input  wire rcld_cap_t  i_remote_cap_port1,
    input  wire logic       i_rev_valid,
    input  wire rcld_req_t  i_req,
    output logic [7:0]      o_rdata,
    output logic            o_link_detect,
    output logic [2:0]      o_fast_control_channel_mode,
    output logic            o_mode_gpio,
    output logic            o_mode_spi_fwd,
    output logic            o_mode_spi_rev,
    output logic            o_mode_reserved
);
    // Cycle counts derived from the periods (longest time, rounded down)
    localparam logic [RCLD_CNT_W-1:0] C0 =
        RCLD_CNT_W'(RCLD_T0_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C1 =
        RCLD_CNT_W'(RCLD_T1_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C2 =
        RCLD_CNT_W'(RCLD_T2_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C3 =
        RCLD_CNT_W'(RCLD_T3_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C4 =
        RCLD_CNT_W'(RCLD_T4_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C5 =
        RCLD_CNT_W'(RCLD_T5_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C6 =
        RCLD_CNT_W'(RCLD_T6_NS * RCLD_CLK_MHZ / 1000);
    localparam logic [RCLD_CNT_W-1:0] C7 =
        RCLD_CNT_W'(RCLD_T7_NS * RCLD_CLK_MHZ / 1000);

    logic       wr_first;
    logic       wr_second;
    logic       wr_ldt;
    logic [1:0] wr_first_p;
    logic [1:0] wr_second_p;
    logic [1:0] hold_p;
    rcld_cap_t  cap_p [2];
    rcld_cap_t  cap_view;
    logic       hold_view;
    logic [7:0] first_view;
    logic [7:0] second_view;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic [2:0] ldt_code_r;
    logic [RCLD_CNT_W-1:0] period;
    logic [RCLD_CNT_W-1:0] cnt_r;
    logic [RCLD_CNT_W-1:0] cnt_nxt;
    logic       link_r;
    logic       link_nxt;
    logic [2:0] mode_r;
    logic       gpio_r;
    logic       fspi_r;
    logic       rspi_r;
    logic       rsv_r;

    // Write decode, routed to the port chosen by the view select
    assign wr_first  = i_req.wr & (i_req.addr == RCLD_CAP_FIRST_ADDR);
    assign wr_second = i_req.wr & (i_req.addr == RCLD_CAP_SECOND_ADDR);
    assign wr_ldt    = i_req.wr & (i_req.addr == RCLD_LDT_CTRL_ADDR);
    assign wr_first_p  = i_second_port_view_select ?           // see R5
        {wr_first, 1'b0} : {1'b0, wr_first};
    assign wr_second_p = i_second_port_view_select ?
        {wr_second, 1'b0} : {1'b0, wr_second};

    // One capability store per link port
    rcld_cap_port u_port0 (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_lock       (i_lock_port0),
        .i_remote_cap (i_remote_cap_port0),
        .i_wr_first   (wr_first_p[0]),
        .i_wr_second  (wr_second_p[0]),
        .i_wdata      (i_req.wdata),
        .o_hold       (hold_p[0]),
        .o_cap        (cap_p[0])
    );
    rcld_cap_port u_port1 (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_lock       (i_lock_port1),
        .i_remote_cap (i_remote_cap_port1),
        .i_wr_first   (wr_first_p[1]),
        .i_wr_second  (wr_second_p[1]),
        .i_wdata      (i_req.wdata),
        .o_hold       (hold_p[1]),
        .o_cap        (cap_p[1])
    );

    // Register views of the selected port
    assign cap_view  = cap_p[i_second_port_view_select];      // see R5
    assign hold_view = hold_p[i_second_port_view_select];
    assign first_view = {hold_view,                            // see R4
        cap_view.fast_control_channel_mode[0],                 // see R8
        3'h0,
        cap_view.secondary_role,                               // see R1
        cap_view.wide_video_with_hd_sound_cap,                 // see R6
        cap_view.forward_frame_gpio_cap} & RCLD_FIRST_MASK;    // see R7
    assign second_view = {6'h00,
        cap_view.fast_control_channel_mode[2:1]} & RCLD_SECOND_MASK;
    assign rdata_nxt =
        (i_req.addr == RCLD_CAP_FIRST_ADDR)  ? first_view :
        (i_req.addr == RCLD_CAP_SECOND_ADDR) ? second_view :
        (i_req.addr == RCLD_LDT_CTRL_ADDR)   ?
            ({5'h00, ldt_code_r} & RCLD_LDT_MASK) : RCLD_RESET_VAL;

    // Timeout period lookup
    always_comb begin
        case (ldt_code_r)                                      // see R12
            3'h0:    period = C0;
            3'h1:    period = C1;
            3'h2:    period = C2;
            3'h3:    period = C3;
            3'h4:    period = C4;
            3'h5:    period = C5;
            3'h6:    period = C6;
            3'h7:    period = C7;
            default: period = C0;
        endcase
    end

    // Link-detect countdown
    always_comb begin
        cnt_nxt  = cnt_r;
        link_nxt = link_r;
        if (i_rev_valid) begin
            cnt_nxt  = period;                                 // see R13
            link_nxt = 1'b1;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - RCLD_CNT_W'(1);
        end else begin
            link_nxt = 1'b0;                                   // see R11
        end
    end

    // Mode decode from the selected port
    logic [2:0] mode_view;
    assign mode_view = cap_view.fast_control_channel_mode;     // see R8

    // Registers and output flops
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r    <= RCLD_RESET_VAL;
            ldt_code_r <= 3'h0;
            cnt_r      <= '0;
            link_r     <= 1'b0;
            mode_r     <= 3'h0;
            gpio_r     <= 1'b0;
            fspi_r     <= 1'b0;
            rspi_r     <= 1'b0;
            rsv_r      <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            if (wr_ldt) begin
                ldt_code_r <= i_req.wdata[2:0];
            end
            cnt_r  <= cnt_nxt;
            link_r <= link_nxt;
            mode_r <= mode_view;
            gpio_r <= (mode_view <= RCLD_MODE_GPIO4);          // see R9
            rsv_r  <= (mode_view == RCLD_MODE_RSV4) ||
                      (mode_view == RCLD_MODE_RSV5);           // see R9
            fspi_r <= (mode_view == RCLD_MODE_FSPI);           // see R10
            rspi_r <= (mode_view == RCLD_MODE_RSPI);           // see R10
        end
    end

    assign o_rdata                     = rdata_r;
    assign o_link_detect               = link_r;
    assign o_fast_control_channel_mode = mode_r;
    assign o_mode_gpio                 = gpio_r;
    assign o_mode_spi_fwd              = fspi_r;
    assign o_mode_spi_rev              = rspi_r;
    assign o_mode_reserved             = rsv_r;

    property p_link_drop;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_rev_valid && cnt_r == '0) |=> !o_link_detect;
    endproperty
    a_link_drop: assert property (p_link_drop) // see R11
        else $error("link detect held after timeout");

    property p_restart;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_rev_valid |=> (cnt_r == $past(period)) && o_link_detect;
    endproperty
    a_restart: assert property (p_restart) // see R13
        else $error("timer not restarted by traffic");

    property p_short_period;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (ldt_code_r == 3'h4) |-> (period == 19'h00A02);
    endproperty
    a_short_period: assert property (p_short_period) // see R12
        else $error("wrong period for code 4");

    // Reset code selects the shortest of the four long periods, 162 us in cycles
    property p_long_period;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (ldt_code_r == 3'h0) |-> (period == 19'h09E34);
    endproperty
    a_long_period: assert property (p_long_period) // see R12
        else $error("wrong period for code 0");

    property p_role_read;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_req.addr == RCLD_CAP_FIRST_ADDR)
            |=> (o_rdata[RCLD_ROLE_BIT] == $past(cap_view.secondary_role));
    endproperty
    a_role_read: assert property (p_role_read) // see R1
        else $error("role bit read mismatch");

    property p_mode_join;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_fast_control_channel_mode ==
            {$past(second_view[1:0]), $past(first_view[RCLD_MODE0_BIT])});
    endproperty
    a_mode_join: assert property (p_mode_join) // see R8
        else $error("mode bits mis-joined");

    property p_spi_decode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_fast_control_channel_mode == 3'h7) |-> o_mode_spi_rev
            && !o_mode_spi_fwd && !o_mode_gpio && !o_mode_reserved;
    endproperty
    a_spi_decode: assert property (p_spi_decode) // see R10
        else $error("reverse SPI mode misdecoded");

    property p_rsv_decode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_fast_control_channel_mode[2:1] == 2'h2) |-> o_mode_reserved
            && !o_mode_gpio;
    endproperty
    a_rsv_decode: assert property (p_rsv_decode) // see R9
        else $error("reserved mode misdecoded");

    property p_view_sel;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_second_port_view_select && i_req.addr == RCLD_CAP_FIRST_ADDR)
            |=> o_rdata[RCLD_HDSND_BIT]
                == $past(cap_p[1].wide_video_with_hd_sound_cap);
    endproperty
    a_view_sel: assert property (p_view_sel) // see R5 see R6
        else $error("second port not shown");
endmodule

// ### hw/rcld_pkg.sv
// Package with register map, field layout and timing constants
package rcld_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] RCLD_CAP_FIRST_ADDR  = 8'h20;
    localparam logic [7:0] RCLD_CAP_SECOND_ADDR = 8'h21;
    localparam logic [7:0] RCLD_LDT_CTRL_ADDR   = 8'h26;
    localparam logic [7:0] RCLD_RESET_VAL       = 8'h00;

    // Field positions in the first capability register
    localparam int RCLD_HOLD_BIT = 7;
    localparam int RCLD_MODE0_BIT = 6;
    localparam int RCLD_ROLE_BIT = 2;
    localparam int RCLD_HDSND_BIT = 1;
    localparam int RCLD_FGPIO_BIT = 0;

    // Writable masks; bits 5:3 of the first register live elsewhere
    localparam logic [7:0] RCLD_FIRST_MASK  = 8'hC7;
    localparam logic [7:0] RCLD_SECOND_MASK = 8'h03;
    localparam logic [7:0] RCLD_LDT_MASK    = 8'h07;

    // Clock rate and link-detect periods in nanoseconds
    localparam int RCLD_CLK_MHZ = 250;
    localparam int RCLD_T0_NS = 162000;
    localparam int RCLD_T1_NS = 325000;
    localparam int RCLD_T2_NS = 650000;
    localparam int RCLD_T3_NS = 1300000;
    localparam int RCLD_T4_NS = 10250;
    localparam int RCLD_T5_NS = 20500;
    localparam int RCLD_T6_NS = 41000;
    localparam int RCLD_T7_NS = 82000;
    localparam int RCLD_CNT_W = 19;

    // Fast control-channel mode codes
    typedef enum logic [2:0] {
        RCLD_MODE_NORMAL = 3'h0,
        RCLD_MODE_GPIO1  = 3'h1,
        RCLD_MODE_GPIO2  = 3'h2,
        RCLD_MODE_GPIO4  = 3'h3,
        RCLD_MODE_RSV4   = 3'h4,
        RCLD_MODE_RSV5   = 3'h5,
        RCLD_MODE_FSPI   = 3'h6,
        RCLD_MODE_RSPI   = 3'h7
    } rcld_mode_t;

    // Capability set delivered by the remote receiver
    typedef struct packed {
        logic       secondary_role;
        logic       wide_video_with_hd_sound_cap;
        logic       forward_frame_gpio_cap;
        logic [2:0] fast_control_channel_mode;
    } rcld_cap_t;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcld_req_t;

endpackage

// ### hw/rcld_cap_port.sv
// One link port's capability store with hold and auto-load
`timescale 1ns/10ps
module rcld_cap_port
    import rcld_pkg::*;
(
    input  wire logic      i_core_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_lock,
    input  wire rcld_cap_t i_remote_cap,
    input  wire logic      i_wr_first,
    input  wire logic      i_wr_second,
    input  wire logic [7:0] i_wdata,
    output logic      o_hold,
    output rcld_cap_t o_cap
);
    rcld_cap_t cap_r;
    rcld_cap_t cap_nxt;
    logic      hold_r;
    logic      hold_nxt;
    logic      load;

    // Auto-load runs only when locked and not held
    assign load = i_lock & ~hold_r & ~i_wr_first & ~i_wr_second;

    // Next capability value: software write, else remote load
    always_comb begin
        cap_nxt  = cap_r;
        hold_nxt = hold_r;
        if (i_wr_first) begin
            hold_nxt = i_wdata[RCLD_HOLD_BIT];
            cap_nxt.fast_control_channel_mode[0] = i_wdata[RCLD_MODE0_BIT];
            cap_nxt.secondary_role = i_wdata[RCLD_ROLE_BIT];
            cap_nxt.wide_video_with_hd_sound_cap = i_wdata[RCLD_HDSND_BIT];
            cap_nxt.forward_frame_gpio_cap = i_wdata[RCLD_FGPIO_BIT];
        end
        if (i_wr_second) begin
            cap_nxt.fast_control_channel_mode[2:1] = i_wdata[1:0];
        end
        if (load) begin
            cap_nxt = i_remote_cap;                   // see R2 see R4
        end
    end

    // Storage
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_r  <= '0;
            hold_r <= 1'b0;
        end else begin
            cap_r  <= cap_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign o_cap  = cap_r;
    assign o_hold = hold_r;

    property p_hold_keeps;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (hold_r && !i_wr_first && !i_wr_second) |=> $stable(cap_r);
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) // see R4
        else $error("held capability changed");

    property p_auto_load;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_lock && !hold_r && !i_wr_first && !i_wr_second)
            |=> (cap_r == $past(i_remote_cap));
    endproperty
    a_auto_load: assert property (p_auto_load) // see R2
        else $error("capability not loaded after lock");
endmodule

// ### sim/rcld_remote_model.sv
// Behavioural remote receiver: lock, capability words, reverse traffic
`timescale 1ns/10ps
module rcld_remote_model
    import rcld_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic [1:0] i_lock_en,
    input  wire rcld_cap_t  i_cap0,
    input  wire rcld_cap_t  i_cap1,
    input  wire logic       i_send,
    output logic            o_lock0     = 1'b0,
    output logic            o_lock1     = 1'b0,
    output rcld_cap_t       o_cap0      = '0,
    output rcld_cap_t       o_cap1      = '0,
    output logic            o_rev_valid = 1'b0
);
    logic [5:0] junk_r = 6'h15;

    // Unlocked ports show a word that changes every cycle
    always @(posedge i_core_clk) begin
        junk_r      <= junk_r + 6'h0B;
        o_lock0     <= i_lock_en[0];
        o_lock1     <= i_lock_en[1];
        o_cap0      <= i_lock_en[0] ? i_cap0 : junk_r;
        o_cap1      <= i_lock_en[1] ? i_cap1 : ~junk_r;
        o_rev_valid <= i_send;
    end
endmodule

// ### sim/rcld_top_tb_top.sv
// Self-checking bench for the capability store and link-detect timer
`timescale 1ns/10ps
module rcld_top_tb_top;
    import rcld_pkg::*;
    typedef struct packed {
        logic [7:0] rd;
        logic [2:0] md;
        logic       cm;
    } rcld_note_t;
    logic       i_core_clk = 1'b0;
    logic       i_rst_n    = 1'b0;
    logic       sel        = 1'b0;
    logic       send       = 1'b0;
    logic       rd_stb     = 1'b0;
    logic       rd_d       = 1'b0;
    logic [1:0] lock_en    = 2'b00;
    rcld_cap_t  cap0       = '0;
    rcld_cap_t  cap1       = '0;
    rcld_req_t  req        = '0;
    rcld_cap_t  rc0, rc1;
    logic       lk0, lk1, rv, lnk, g, fs, rs, rsv;
    logic [7:0] rdata;
    logic [2:0] md;
    rcld_note_t q[$];
    rcld_note_t nt;
    int         n_fail  = 0;
    int         n_tests = 0;
    int         per_ns[8] = '{RCLD_T0_NS, RCLD_T1_NS, RCLD_T2_NS, RCLD_T3_NS,
                              RCLD_T4_NS, RCLD_T5_NS, RCLD_T6_NS, RCLD_T7_NS};

    rcld_remote_model u_rcld_remote_model (
        .i_core_clk(i_core_clk), .i_lock_en(lock_en), .i_cap0(cap0),
        .i_cap1(cap1), .i_send(send), .o_lock0(lk0), .o_lock1(lk1),
        .o_cap0(rc0), .o_cap1(rc1), .o_rev_valid(rv));

    rcld_top u_rcld_top (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_second_port_view_select(sel), .i_lock_port0(lk0),
        .i_lock_port1(lk1), .i_remote_cap_port0(rc0),
        .i_remote_cap_port1(rc1), .i_rev_valid(rv), .i_req(req),
        .o_rdata(rdata), .o_link_detect(lnk),
        .o_fast_control_channel_mode(md), .o_mode_gpio(g),
        .o_mode_spi_fwd(fs), .o_mode_spi_rev(rs), .o_mode_reserved(rsv));

    // Clock at 4 ns
    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk1(string nm, logic e, logic s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic test_done();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_core_clk);
        req <= '{1'b1, a, d};
        @(posedge i_core_clk);
        req.wr <= 1'b0;
    endtask

    // Read request; the expected answer is noted for the watcher
    task automatic rd(logic [7:0] a, rcld_note_t n);
        @(posedge i_core_clk);
        req.addr <= a;
        rd_stb   <= 1'b1;
        q.push_back(n);
        @(posedge i_core_clk);
        rd_stb <= 1'b0;
    endtask

    task automatic chk_cap(logic h, rcld_cap_t c);
        rd(RCLD_CAP_FIRST_ADDR, '{{h, c.fast_control_channel_mode[0], 3'h0,
            c.secondary_role, c.wide_video_with_hd_sound_cap,
            c.forward_frame_gpio_cap}, 3'h0, 1'b0});
        rd(RCLD_CAP_SECOND_ADDR, '{{6'h00, c.fast_control_channel_mode[2:1]},
            c.fast_control_channel_mode, 1'b1});
    endtask

    // Watcher: compares each read answer with the oldest note
    always @(posedge i_core_clk) rd_d <= rd_stb;
    always @(negedge i_core_clk) begin
        if (rd_d) begin
            nt = q.pop_front();
            chk8("rdata", nt.rd, rdata);
            if (nt.cm) begin
                chk8("mode", {5'h00, nt.md}, {5'h00, md});
                chk1("gpio", nt.md <= 3'h3, g);
                chk1("reserved", nt.md[2:1] == 2'b10, rsv);
                chk1("fwd_spi", nt.md == 3'h6, fs);
                chk1("rev_spi", nt.md == 3'h7, rs);
            end
        end
    end

    // Main sequence
    initial begin
        rcld_cap_t  c0, c1, cw;
        logic [7:0] w, s;
        int         p, n, n0;
        void'($urandom(32'h8851));
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        // Reset values, unmapped address
        foreach (per_ns[k]) if (k < 4)
            rd(8'h20 + 8'(k) + (k == 3 ? 8'h03 : 8'h00), '0);
        @(negedge i_core_clk);
        chk1("link_reset", 1'b0, lnk);
        // Auto-load of every mode code on both ports, read back from port 0 for even codes, port 1 for odd
        lock_en <= 2'b11;
        for (int m = 0; m < 8; m++) begin
            c0 = 6'($urandom);
            c1 = 6'($urandom);
            c0.fast_control_channel_mode = 3'(m);
            c1.fast_control_channel_mode = 3'(m);
            @(posedge i_core_clk);
            cap0 <= c0;
            cap1 <= c1;
            sel  <= m[0];
            repeat (4) @(posedge i_core_clk);
            chk_cap(1'b0, m[0] ? c1 : c0);
        end
        // Unlocked port keeps the last loaded set
        @(posedge i_core_clk);
        lock_en <= 2'b10;
        sel     <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        chk_cap(1'b0, c0);
        // Held software values on port 1 survive auto-load
        lock_en <= 2'b11;
        sel     <= 1'b1;
        w = (8'($urandom) & RCLD_FIRST_MASK) | 8'hB8;
        s = 8'($urandom) | 8'hFC;
        wr(RCLD_CAP_FIRST_ADDR, w);
        wr(RCLD_CAP_SECOND_ADDR, s);
        cw = {w[2:0], s[1:0], w[6]};
        repeat (4) @(posedge i_core_clk);
        chk_cap(1'b1, cw);
        sel <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk_cap(1'b0, c0);
        // Write without hold is replaced by auto-load
        wr(RCLD_CAP_FIRST_ADDR, {1'b0, ~c0[0], 3'h0, ~c0[5:3]});
        repeat (4) @(posedge i_core_clk);
        chk_cap(1'b0, c0);
        sel <= 1'b1;
        wr(RCLD_CAP_FIRST_ADDR, 8'h00);
        repeat (4) @(posedge i_core_clk);
        chk_cap(1'b0, c1);
        wr(RCLD_LDT_CTRL_ADDR, 8'hFF);
        rd(RCLD_LDT_CTRL_ADDR, '{8'h07, 3'h0, 1'b0});
        wr(8'h22, 8'hFF);
        rd(8'h22, '0);
        // Link-detect timeouts, short codes
        for (int k = 4; k < 8; k++) begin
            wr(RCLD_LDT_CTRL_ADDR, 8'(k));
            p = per_ns[k] * RCLD_CLK_MHZ / 1000;
            repeat (2) begin
                @(posedge i_core_clk);
                send <= 1'b1;
                @(posedge i_core_clk);
                send <= 1'b0;
                repeat (p * 7 / 8) @(posedge i_core_clk);
                @(negedge i_core_clk);
                chk1("link_up", 1'b1, lnk);
            end
            n  = 0;
            n0 = p - p * 7 / 8 + 2;
            while (lnk !== 1'b0 && n < p) begin
                @(negedge i_core_clk);
                n++;
            end
            if (n >= p) begin
                chk1("link_drop", 1'b0, lnk);
                break;
            end
            chk1("expiry", 1'b1, n >= n0 - 3 && n <= n0 + 3);
        end
        repeat (3) @(posedge i_core_clk);
        test_done();
    end
endmodule
